// [design/perf_event_pkg.sv]
// Package: event codes, unit masks, register map and carrier types for the event decoder
package perf_event_pkg;

    // ------------------------------------------------------------
    // Event numbers
    // ------------------------------------------------------------
    localparam logic [7:0] EV_WIDE_FP     = 8'h11;
    localparam logic [7:0] EV_DIVIDER     = 8'h14;
    localparam logic [7:0] EV_QUEUE_WR    = 8'h17;
    localparam logic [7:0] EV_MID_REQ     = 8'h24;
    localparam logic [7:0] EV_OWN_ACCESS  = 8'h27;
    localparam logic [7:0] EV_WRITEBACK   = 8'h28;
    localparam logic [7:0] EV_LAST_LEVEL  = 8'h2E;
    localparam logic [7:0] EV_UNHALTED    = 8'h3C;
    localparam logic [7:0] EV_PEND_MISS   = 8'h48;
    localparam logic [7:0] EV_STORE_WALK  = 8'h49;

    // ------------------------------------------------------------
    // Unit masks
    // ------------------------------------------------------------
    localparam logic [7:0] UM_00 = 8'h00;
    localparam logic [7:0] UM_01 = 8'h01;
    localparam logic [7:0] UM_02 = 8'h02;
    localparam logic [7:0] UM_03 = 8'h03;
    localparam logic [7:0] UM_04 = 8'h04;
    localparam logic [7:0] UM_08 = 8'h08;
    localparam logic [7:0] UM_0C = 8'h0C;
    localparam logic [7:0] UM_0F = 8'h0F;
    localparam logic [7:0] UM_10 = 8'h10;
    localparam logic [7:0] UM_20 = 8'h20;
    localparam logic [7:0] UM_30 = 8'h30;
    localparam logic [7:0] UM_40 = 8'h40;
    localparam logic [7:0] UM_41 = 8'h41;
    localparam logic [7:0] UM_4F = 8'h4F;
    localparam logic [7:0] UM_80 = 8'h80;
    localparam logic [7:0] UM_C0 = 8'hC0;

    // ------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------
    localparam logic [31:0] OFS_CTRL     = 32'h0000_0000;
    localparam logic [31:0] OFS_COUNT    = 32'h0000_0004;
    localparam logic [31:0] OFS_STATUS   = 32'h0000_0008;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET  = 32'h0000_0000;
    localparam int          CTRL_EVT_LSB = 0;
    localparam int          CTRL_UM_LSB  = 8;
    localparam int          CTRL_EDGE    = 16;
    localparam int          CTRL_EN      = 17;
    localparam int          CTRL_THR_LSB = 24;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------
    // Timing: reference clock against core clock
    // ------------------------------------------------------------
    localparam int          REF_CLK_MHZ  = 100;
    localparam int          CORE_CLK_MHZ = 40;
    localparam logic [7:0]  REF_STEP     = 8'(REF_CLK_MHZ);
    localparam logic [7:0]  CORE_MOD     = 8'(CORE_CLK_MHZ);

    typedef logic [4:0] evcnt_t;

    // Event strobes from the pipeline, caches and TLB, all on core_clk
    typedef struct packed {
        logic       fpSingle;
        logic       fpDouble;
        logic       divBusy;
        logic [2:0] queueWrites;
        logic       dmdRdHit;
        logic       dmdRdMiss;
        logic       l1PfRd;
        logic       rfoHit;
        logic       rfoMiss;
        logic       codeHit;
        logic       codeMiss;
        logic       pfHit;
        logic       pfMiss;
        logic       lockMiss;
        logic       lockHitE;
        logic       lockHitM;
        logic       wbMiss;
        logic       wbHitS;
        logic       wbHitE;
        logic       wbHitM;
        logic       llcRef;
        logic       llcMiss;
        logic       halted;
        logic [3:0] pendMisses;
        logic       storeWalkStart;
        logic       storeWalkDone;
    } event_s;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_s;

endpackage : perf_event_pkg

// [design/perf_event_select_decoder.sv]
// Event-selection decoder with one counter and an AXI4-Lite register slave
`timescale 1ns/1ps

// Notes on behaviour
// - 11H: wide single under 01H, double under 02H
// - 14H/01H: divider busy cycles; edge counts divides
// - 17H/01H: add queue writes each cycle
// - 24H/01H: demand data reads hitting mid cache
// - 24H/03H: all demand plus first-level prefetch loads
// - 24H: ownership hits 04H, misses 08H, all 0CH
// - 24H: fetch hits 10H, misses 20H, all 30H
// - 24H: mid prefetcher hits 40H, misses 80H
// - 27H: ownership miss, E hit, M hit, any
// - 28H: accepted first-level writebacks by line state
// - 2EH/4FH: core references to last-level lines
// - 2EH/41H: each last-level miss condition
// - 3CH/00H: thread cycles outside halt state
// - 3CH/01H: 100 MHz reference ticks while not halted
// - 48H/01H: add pending misses; edge counts occurrences
// - 49H/01H: store misses starting a page walk
// - 49H/02H: store misses whose walk completes
module perf_event_select_decoder (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    // Event strobes
    input  wire perf_event_pkg::event_s    events,
    // Register bus
    input  wire perf_event_pkg::axi_req_s  axiReq,
    output      perf_event_pkg::axi_rsp_s  axiRsp,
    // Counter value
    output      logic [31:0]               eventCount
);
    import perf_event_pkg::*;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic evcnt_t event_inc(input logic [7:0] code, input logic [7:0] mask,
                                         input event_s e, input logic [1:0] refInc);
        evcnt_t n;
        n = '0;
        case ({code, mask})
            {EV_WIDE_FP, UM_01}:     n = evcnt_t'(e.fpSingle);
            {EV_WIDE_FP, UM_02}:     n = evcnt_t'(e.fpDouble);
            {EV_DIVIDER, UM_01}:     n = evcnt_t'(e.divBusy);
            {EV_QUEUE_WR, UM_01}:    n = evcnt_t'(e.queueWrites);
            {EV_MID_REQ, UM_01}:     n = evcnt_t'(e.dmdRdHit);
            {EV_MID_REQ, UM_03}:     n = evcnt_t'(e.dmdRdHit) + evcnt_t'(e.dmdRdMiss)
                                         + evcnt_t'(e.l1PfRd);
            {EV_MID_REQ, UM_04}:     n = evcnt_t'(e.rfoHit);
            {EV_MID_REQ, UM_08}:     n = evcnt_t'(e.rfoMiss);
            {EV_MID_REQ, UM_0C}:     n = evcnt_t'(e.rfoHit) + evcnt_t'(e.rfoMiss);
            {EV_MID_REQ, UM_10}:     n = evcnt_t'(e.codeHit);
            {EV_MID_REQ, UM_20}:     n = evcnt_t'(e.codeMiss);
            {EV_MID_REQ, UM_30}:     n = evcnt_t'(e.codeHit) + evcnt_t'(e.codeMiss);
            {EV_MID_REQ, UM_40}:     n = evcnt_t'(e.pfHit);
            {EV_MID_REQ, UM_80}:     n = evcnt_t'(e.pfMiss);
            {EV_MID_REQ, UM_C0}:     n = evcnt_t'(e.pfHit) + evcnt_t'(e.pfMiss);
            {EV_OWN_ACCESS, UM_01}:  n = evcnt_t'(e.lockMiss);
            {EV_OWN_ACCESS, UM_04}:  n = evcnt_t'(e.lockHitE);
            {EV_OWN_ACCESS, UM_08}:  n = evcnt_t'(e.lockHitM);
            {EV_OWN_ACCESS, UM_0F}:  n = evcnt_t'(e.lockMiss) + evcnt_t'(e.lockHitE)
                                         + evcnt_t'(e.lockHitM);
            {EV_WRITEBACK, UM_01}:   n = evcnt_t'(e.wbMiss);
            {EV_WRITEBACK, UM_02}:   n = evcnt_t'(e.wbHitS);
            {EV_WRITEBACK, UM_04}:   n = evcnt_t'(e.wbHitE);
            {EV_WRITEBACK, UM_08}:   n = evcnt_t'(e.wbHitM);
            {EV_WRITEBACK, UM_0F}:   n = evcnt_t'(e.wbMiss) + evcnt_t'(e.wbHitS)
                                         + evcnt_t'(e.wbHitE) + evcnt_t'(e.wbHitM);
            {EV_LAST_LEVEL, UM_4F}:  n = evcnt_t'(e.llcRef);
            {EV_LAST_LEVEL, UM_41}:  n = evcnt_t'(e.llcMiss);
            {EV_UNHALTED, UM_00}:    n = evcnt_t'(!e.halted);
            {EV_UNHALTED, UM_01}:    n = e.halted ? '0 : evcnt_t'(refInc);
            {EV_PEND_MISS, UM_01}:   n = evcnt_t'(e.pendMisses);
            {EV_STORE_WALK, UM_01}:  n = evcnt_t'(e.storeWalkStart);
            {EV_STORE_WALK, UM_02}:  n = evcnt_t'(e.storeWalkDone);
            default:                 n = '0;
        endcase
        return n;
    endfunction : event_inc

    function automatic logic known_pair(input logic [7:0] code, input logic [7:0] mask);
        logic k;
        k = 1'b0;
        case (code)
            EV_WIDE_FP:    k = (mask == UM_01) || (mask == UM_02);
            EV_DIVIDER,
            EV_QUEUE_WR,
            EV_PEND_MISS:  k = (mask == UM_01);
            EV_MID_REQ:    k = (mask == UM_01) || (mask == UM_03) || (mask == UM_04)
                               || (mask == UM_08) || (mask == UM_0C) || (mask == UM_10)
                               || (mask == UM_20) || (mask == UM_30) || (mask == UM_40)
                               || (mask == UM_80) || (mask == UM_C0);
            EV_OWN_ACCESS: k = (mask == UM_01) || (mask == UM_04) || (mask == UM_08)
                               || (mask == UM_0F);
            EV_WRITEBACK:  k = (mask == UM_01) || (mask == UM_02) || (mask == UM_04)
                               || (mask == UM_08) || (mask == UM_0F);
            EV_LAST_LEVEL: k = (mask == UM_4F) || (mask == UM_41);
            EV_UNHALTED:   k = (mask == UM_00) || (mask == UM_01);
            EV_STORE_WALK: k = (mask == UM_01) || (mask == UM_02);
            default:       k = 1'b0;
        endcase
        return k;
    endfunction : known_pair

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] count;
    logic [7:0]  refPhase;
    logic        prevActive;
    logic [4:0]  lastInc;
    logic [31:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    // Response fields are separate flops so each channel block is their only driver
    logic        awReady;
    logic        wReady;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;

    // ------------------------------------------------------------
    // Selection and counting
    // ------------------------------------------------------------
    wire logic [7:0] selCode   = ctrl[CTRL_EVT_LSB +: 8];
    wire logic [7:0] selMask   = ctrl[CTRL_UM_LSB +: 8];
    wire logic       edgeMode  = ctrl[CTRL_EDGE];
    wire logic       enabled   = ctrl[CTRL_EN];
    wire logic [7:0] threshold = ctrl[CTRL_THR_LSB +: 8];

    // Core clock is slower than the reference, so each core cycle adds two or three ticks
    wire logic [7:0] phaseSum   = refPhase + REF_STEP;
    wire logic [1:0] refInc     = 2'(phaseSum / CORE_MOD);
    wire logic [7:0] next_phase = 8'(phaseSum % CORE_MOD);

    wire evcnt_t     rawInc   = event_inc(selCode, selMask, events, refInc);
    wire logic       selKnown = known_pair(selCode, selMask);
    // Edge with a zero threshold treats any nonzero count as active
    wire logic       active   = (threshold == 8'h00) ? (rawInc != '0)
                                                     : ({3'h0, rawInc} >= threshold);
    wire logic       edgeHit  = active && !prevActive;
    wire evcnt_t     stepInc  = !enabled ? '0
                              : edgeMode ? evcnt_t'(edgeHit)
                              : (threshold != 8'h00) ? evcnt_t'(active)
                              : rawInc;

    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    wire logic       awHeld   = !awReady;
    wire logic       wHeld    = !wReady;
    wire logic       wrFire   = awHeld && wHeld && !bValid;
    wire logic       wrCtrl   = wrFire && (awAddr[7:0] == OFS_CTRL[7:0]) && (awAddr[31:8] == '0);
    wire logic       wrCount  = wrFire && (awAddr[7:0] == OFS_COUNT[7:0]) && (awAddr[31:8] == '0);
    wire logic       wrStat   = wrFire && (awAddr[7:0] == OFS_STATUS[7:0]) && (awAddr[31:8] == '0);
    wire logic       wrMapped = wrCtrl || wrCount || wrStat;
    wire logic       arFire   = axiReq.arvalid && arReady;
    wire logic       rdCtrl   = (axiReq.araddr == OFS_CTRL);
    wire logic       rdCount  = (axiReq.araddr == OFS_COUNT);
    wire logic       rdStat   = (axiReq.araddr == OFS_STATUS);
    wire logic [31:0] statusWord = {18'h0, selKnown, prevActive, 7'h0, lastInc};
    wire logic [31:0] rdMux   = rdCtrl  ? ctrl
                              : rdCount ? count
                              : rdStat  ? statusWord
                              : 32'h0000_0000;
    // A software write to the counter takes priority over that cycle's increment
    wire logic [31:0] next_count = wrCount ? merge_bytes(count, wData, wStrb)
                                           : count + 32'(stepInc);

    // ------------------------------------------------------------
    // Counter datapath
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl       <= CTRL_RESET;
            count      <= COUNT_RESET;
            refPhase   <= 8'h00;
            prevActive <= 1'b0;
            lastInc    <= 5'h00;
        end else begin
            if (wrCtrl) begin
                ctrl <= merge_bytes(ctrl, wData, wStrb);
            end
            count      <= next_count;
            refPhase   <= next_phase;
            prevActive <= active && enabled;
            lastInc    <= stepInc;
        end
    end

    assign eventCount = count;
    assign axiRsp     = {awReady, wReady, bValid, bResp, arReady, rValid, rData, rResp};

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            awReady <= 1'b1;
            wReady  <= 1'b1;
            bValid  <= 1'b0;
            bResp   <= RESP_OKAY;
            awAddr  <= 32'h0000_0000;
            wData   <= 32'h0000_0000;
            wStrb   <= 4'h0;
        end else begin
            if (axiReq.awvalid && awReady) begin
                awAddr  <= axiReq.awaddr;
                awReady <= 1'b0;
            end
            if (axiReq.wvalid && wReady) begin
                wData  <= axiReq.wdata;
                wStrb  <= axiReq.wstrb;
                wReady <= 1'b0;
            end
            if (wrFire) begin
                bValid <= 1'b1;
                bResp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bValid && axiReq.bready) begin
                bValid  <= 1'b0;
                awReady <= 1'b1;
                wReady  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            arReady <= 1'b1;
            rValid  <= 1'b0;
            rData   <= 32'h0000_0000;
            rResp   <= RESP_OKAY;
        end else if (arFire) begin
            arReady <= 1'b0;
            rValid  <= 1'b1;
            rData   <= rdMux;
            rResp   <= (rdCtrl || rdCount || rdStat) ? RESP_OKAY : RESP_SLVERR;
        end else if (rValid && axiReq.rready) begin
            rValid  <= 1'b0;
            arReady <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    wire logic plain = enabled && !edgeMode && (threshold == 8'h00) && !wrCount;

    property p_wide_double;
        @(posedge core_clk) disable iff (!nrst)
        (plain && selCode == EV_WIDE_FP && selMask == UM_02 && events.fpDouble)
            |=> (count == $past(count) + 32'h1);
    endproperty
    a_wide_double: assert property (p_wide_double) else $error("double fp not counted");

    property p_divider;
        @(posedge core_clk) disable iff (!nrst)
        (plain && selCode == EV_DIVIDER && selMask == UM_01 && !events.divBusy)
            |=> (count == $past(count));
    endproperty
    a_divider: assert property (p_divider) else $error("idle divider counted");

    property p_queue;
        @(posedge core_clk) disable iff (!nrst)
        (plain && selCode == EV_QUEUE_WR && selMask == UM_01)
            |=> (count == $past(count) + 32'($past(events.queueWrites)));
    endproperty
    a_queue: assert property (p_queue) else $error("queue writes miscounted");

    property p_halted_ref;
        @(posedge core_clk) disable iff (!nrst)
        (plain && selCode == EV_UNHALTED && selMask == UM_01 && !events.halted)
            |=> (count - $past(count) inside {32'h2, 32'h3});
    endproperty
    a_halted_ref: assert property (p_halted_ref) else $error("reference step wrong");

    property p_unhalted;
        @(posedge core_clk) disable iff (!nrst)
        (plain && selCode == EV_UNHALTED && selMask == UM_00)
            |=> (count == $past(count) + 32'(!$past(events.halted)));
    endproperty
    a_unhalted: assert property (p_unhalted) else $error("unhalted cycles miscounted");

    property p_store_walk;
        @(posedge core_clk) disable iff (!nrst)
        (plain && selCode == EV_STORE_WALK && selMask == UM_02)
            |=> (count == $past(count) + 32'($past(events.storeWalkDone)));
    endproperty
    a_store_walk: assert property (p_store_walk) else $error("completed walks miscounted");

    property p_pending;
        @(posedge core_clk) disable iff (!nrst)
        (plain && selCode == EV_PEND_MISS && selMask == UM_01)
            |=> (count == $past(count) + 32'($past(events.pendMisses)));
    endproperty
    a_pending: assert property (p_pending) else $error("pending misses miscounted");

    property p_threshold;
        @(posedge core_clk) disable iff (!nrst)
        (enabled && !edgeMode && threshold != 8'h00 && !wrCount)
            |=> (count == $past(count) + 32'({3'h0, $past(rawInc)} >= $past(threshold)));
    endproperty
    a_threshold: assert property (p_threshold) else $error("threshold count wrong");

    property p_edge_once;
        @(posedge core_clk) disable iff (!nrst)
        (enabled && edgeMode && !wrCount && active && prevActive) |=> $stable(count);
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge counted twice");

    property p_unknown;
        @(posedge core_clk) disable iff (!nrst)
        (!selKnown && !wrCount) |=> (count == $past(count));
    endproperty
    a_unknown: assert property (p_unknown) else $error("unlisted pair counted");

    property p_write_resp;
        @(posedge core_clk) disable iff (!nrst)
        wrFire |=> axiRsp.bvalid ##0 (axiRsp.bresp == (($past(wrMapped)) ? RESP_OKAY : RESP_SLVERR));
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response wrong");

endmodule : perf_event_select_decoder

// [sim/event_source_model.sv]
// Event source model: random strobes from pipeline, caches and TLB
`timescale 1ns/1ps
module event_source_model (
    // Clock and control
    input  wire logic              core_clk,
    input  wire logic              run,
    // Event strobes
    output perf_event_pkg::event_s events
);
    import perf_event_pkg::*;
    // Idle is halted with nothing pending, so no pair can count between bursts
    localparam event_s IDLE = '{halted: 1'b1, default: '0};
    initial events = IDLE;
    always @(posedge core_clk) begin
        events <= run ? event_s'($bits(event_s)'($urandom)) : IDLE;
    end
endmodule : event_source_model

// [sim/tb_perf_event_select_decoder.sv]
// Testbench: programs event pairs over AXI4-Lite and compares counts with a model
`timescale 1ns/1ps
module tb_perf_event_select_decoder;
    import perf_event_pkg::*;
    logic        core_clk = 1'b0;
    logic        nrst     = 1'b0;
    logic        run      = 1'b0;
    logic        monOn    = 1'b0;
    logic        edg      = 1'b0;
    logic        prevAct;
    logic        act;
    logic [7:0]  thr      = 8'h00;
    logic [7:0]  phase    = 8'h00;
    logic [7:0]  r;
    logic [15:0] cfgPair;
    logic [4:0]  refInc;
    logic [31:0] eventCount;
    logic [31:0] expCnt;
    logic [31:0] rdat;
    logic [1:0]  resp;
    event_s      events;
    axi_req_s    req = '0;
    axi_rsp_s    rsp;
    int          err_total = 0;
    int          samples_checked = 0;
    logic [15:0] pairs [33] = '{16'h1101, 16'h1102, 16'h1401, 16'h1701, 16'h2401, 16'h2403,
        16'h2404, 16'h2408, 16'h240C, 16'h2410, 16'h2420, 16'h2430, 16'h2440, 16'h2480,
        16'h24C0, 16'h2701, 16'h2704, 16'h2708, 16'h270F, 16'h2801, 16'h2802, 16'h2804,
        16'h2808, 16'h280F, 16'h2E4F, 16'h2E41, 16'h3C00, 16'h3C01, 16'h4801, 16'h4901,
        16'h4902, 16'h2402, 16'h5501};

    initial forever #12.5 core_clk = ~core_clk;

    perf_event_select_decoder i_dut (.core_clk(core_clk), .nrst(nrst), .events(events),
        .axiReq(req), .axiRsp(rsp), .eventCount(eventCount));
    event_source_model i_src (.core_clk(core_clk), .run(run), .events(events));

    // ------------------------------------------------------------
    // Expected per-cycle count of one pair
    // ------------------------------------------------------------
    function automatic logic [7:0] raw_of(input logic [15:0] p, input event_s e,
                                          input logic [4:0] rf);
        case (p)
            16'h1101: return 8'(e.fpSingle);
            16'h1102: return 8'(e.fpDouble);
            16'h1401: return 8'(e.divBusy);
            16'h1701: return 8'(e.queueWrites);
            16'h2401: return 8'(e.dmdRdHit);
            16'h2403: return 8'(e.dmdRdHit) + 8'(e.dmdRdMiss) + 8'(e.l1PfRd);
            16'h2404: return 8'(e.rfoHit);
            16'h2408: return 8'(e.rfoMiss);
            16'h240C: return 8'(e.rfoHit) + 8'(e.rfoMiss);
            16'h2410: return 8'(e.codeHit);
            16'h2420: return 8'(e.codeMiss);
            16'h2430: return 8'(e.codeHit) + 8'(e.codeMiss);
            16'h2440: return 8'(e.pfHit);
            16'h2480: return 8'(e.pfMiss);
            16'h24C0: return 8'(e.pfHit) + 8'(e.pfMiss);
            16'h2701: return 8'(e.lockMiss);
            16'h2704: return 8'(e.lockHitE);
            16'h2708: return 8'(e.lockHitM);
            16'h270F: return 8'(e.lockMiss) + 8'(e.lockHitE) + 8'(e.lockHitM);
            16'h2801: return 8'(e.wbMiss);
            16'h2802: return 8'(e.wbHitS);
            16'h2804: return 8'(e.wbHitE);
            16'h2808: return 8'(e.wbHitM);
            16'h280F: return 8'(e.wbMiss) + 8'(e.wbHitS) + 8'(e.wbHitE) + 8'(e.wbHitM);
            16'h2E4F: return 8'(e.llcRef);
            16'h2E41: return 8'(e.llcMiss);
            16'h3C00: return 8'(!e.halted);
            16'h3C01: return 8'(rf);
            16'h4801: return 8'(e.pendMisses);
            16'h4901: return 8'(e.storeWalkStart);
            16'h4902: return 8'(e.storeWalkDone);
            default:  return 8'h00;
        endcase
    endfunction : raw_of

    // Reference ticks: 100 MHz seen from 40 MHz, phase always runs, ticks count only unhalted
    always @(posedge core_clk) begin
        refInc = 5'h00;
        if (!nrst) phase = 8'h00;
        else begin
            refInc = events.halted ? 5'h00 : 5'((phase + 8'd100) / 8'd40);
            phase  = (phase + 8'd100) % 8'd40;
        end
        if (monOn) begin
            r   = raw_of(cfgPair, events, refInc);
            act = (thr != 8'h00) ? (r >= thr) : (r != 8'h00);
            expCnt += edg ? 32'(act && !prevAct) : ((thr != 8'h00) ? 32'(act) : 32'(r));
            prevAct = act;
        end
    end

    task automatic summarize();
        if (err_total == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : chk

    // ------------------------------------------------------------
    // AXI4-Lite master: readiness looked at mid-cycle, taken at the next edge
    // ------------------------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int   n;
        logic aw, w, b;
        @(posedge core_clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(negedge core_clk);
            aw   = req.awvalid & rsp.awready;
            w    = req.wvalid & rsp.wready;
            b    = rsp.bvalid;
            resp = rsp.bresp;
            @(posedge core_clk);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
            if (b) begin
                req.bready <= 1'b0;
                break;
            end
        end
        if (n == 64) begin
            err_total++;
            summarize();
        end
    endtask : wr

    task automatic rd(input logic [31:0] a);
        int   n;
        logic ar, rv;
        @(posedge core_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(negedge core_clk);
            ar   = req.arvalid & rsp.arready;
            rv   = rsp.rvalid;
            rdat = rsp.rdata;
            resp = rsp.rresp;
            @(posedge core_clk);
            if (ar) req.arvalid <= 1'b0;
            if (rv) begin
                req.rready <= 1'b0;
                break;
            end
        end
        if (n == 64) begin
            err_total++;
            summarize();
        end
    endtask : rd

    initial begin
        void'($urandom(32'hffc5));
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        rd(OFS_CTRL);
        chk(rdat, CTRL_RESET);
        rd(OFS_COUNT);
        chk(rdat, COUNT_RESET);
        rd(32'h0000_0010);
        chk({rdat[31:2], resp}, {30'h0, RESP_SLVERR});
        wr(32'h0000_0010, 32'hFFFF_FFFF);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        // Pass 0 plain counting, pass 1 random threshold and edge detection
        for (int pass = 0; pass < 2; pass++) begin
            for (int i = 0; i < 33; i++) begin
                cfgPair = pairs[i];
                thr     = pass ? 8'($urandom_range(3, 0)) : 8'h00;
                edg     = pass ? 1'($urandom_range(1, 0)) : 1'b0;
                if (pass && (cfgPair == 16'h1401 || cfgPair == 16'h4801)) thr = 8'h01;
                wr(OFS_CTRL, {thr, 6'h00, 1'b1, edg, cfgPair[7:0], cfgPair[15:8]});
                wr(OFS_COUNT, 32'h0000_0000);
                expCnt  = 32'h0000_0000;
                prevAct = 1'b0;
                monOn <= 1'b1;
                run <= 1'b1;
                repeat ($urandom_range(40, 8)) @(posedge core_clk);
                run <= 1'b0;
                repeat (3) @(posedge core_clk);
                monOn <= 1'b0;
                rd(OFS_COUNT);
                chk(rdat, expCnt);
                chk(eventCount, expCnt);
                rd(OFS_STATUS);
                chk(rdat, {18'h0, 1'(i < 31), 13'h0000});
            end
        end
        summarize();
    end
endmodule : tb_perf_event_select_decoder
